// ==== hdl/lpnpia_pkg.sv ====
// Constants for the partner next page and indirect access register slice.
// Notes on behaviour
// - Bit 15 reports partner more-pages flag.
// - Bit 14 updated by negotiation from bursts.
// - Bit 13 page type, one after reset.
// - Bit 12 reports partner will-comply flag.
// - Bit 11 inverse of received toggle bit.
// - Bits 10:0 hold partner page payload.
// - Payload resets to the null page code.
// - Function 00 address, 01 data no increment.
// - 10 increments on all, 11 writes only.
// - Control bits 13:5 read zero, ignore writes.
// - Function 00 window is address register.
// - Nonzero function window is data register.
package lpnpia_pkg;
    localparam int BUS_AW = 8;
    localparam int BUS_DW = 32;
    localparam int IDX_W = 6;
    localparam logic [IDX_W-1:0] IDX_LP_PAGE = 6'h08;
    localparam logic [IDX_W-1:0] IDX_IND_CTRL = 6'h0d;
    localparam logic [IDX_W-1:0] IDX_IND_WIN = 6'h0e;
    localparam logic [15:0] RST_LP_PAGE = 16'h2001;
    localparam logic [15:0] RST_IND_CTRL = 16'h0000;
    localparam logic [15:0] RST_IND_WIN = 16'h0000;
    localparam int BIT_MORE = 15;
    localparam int BIT_ACK = 14;
    localparam int BIT_TYPE = 13;
    localparam int BIT_COMPLY = 12;
    localparam int BIT_TOG = 11;
    localparam int FUNC_HI = 15;
    localparam int FUNC_LO = 14;
    localparam int DEV_HI = 4;
    localparam int DEV_LO = 0;
    localparam logic [4:0] EXT_DEVSEL = 5'h1f;
    localparam int EXT_AW = 5;
    typedef enum logic [1:0] {
        FN_ADDR = 2'h0,
        FN_DATA = 2'h1,
        FN_DATA_INC_RW = 2'h2,
        FN_DATA_INC_W = 2'h3
    } lpnpia_fn_e;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_DONE
    } lpnpia_st_e;
endpackage : lpnpia_pkg

// ==== hdl/lpnpia_mem_if.sv ====
// Port bundle between the register slice and its extended register memory.
`timescale 1ns/1ps
interface lpnpia_mem_if #(
    parameter int AW = 5
);
    logic rd_en;
    logic wr_en;
    logic [AW-1:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport ctl (output rd_en, output wr_en, output addr, output wdata, input rdata);
    modport mem (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface : lpnpia_mem_if

// ==== hdl/lpnpia_ext_mem.sv ====
// Extended register storage with registered read data.
`timescale 1ns/1ps
module lpnpia_ext_mem #(
    parameter int AW = 5
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    lpnpia_mem_if.mem mem_if
);
    localparam int DEPTH = 1 << AW;
    typedef struct packed {
        logic [DEPTH-1:0][15:0] words;
        logic [15:0] rdata;
    } lpnpia_mem_s;
    lpnpia_mem_s st_ff;
    lpnpia_mem_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (mem_if.rd_en) begin
            nxt_st.rdata = st_ff.words[mem_if.addr];
        end
        if (mem_if.wr_en) begin
            nxt_st.words[mem_if.addr] = mem_if.wdata;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign mem_if.rdata = st_ff.rdata;
endmodule : lpnpia_ext_mem

// ==== hdl/lpnpia_top.sv ====
// Partner next page register and indirect access window on an Avalon-MM slave.
`timescale 1ns/1ps
module lpnpia_top #(
    parameter int EXT_AW = lpnpia_pkg::EXT_AW
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [lpnpia_pkg::BUS_AW-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [lpnpia_pkg::BUS_DW-1:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [lpnpia_pkg::BUS_DW-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic an_page_load_in,
    input wire logic [15:0] an_page_in,
    input wire logic an_ack_update_in,
    input wire logic an_ack_in
);
    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        lpnpia_pkg::lpnpia_st_e state;
        logic [15:0] readdata;
        logic [1:0] func;
        logic [4:0] devsel;
        logic [15:0] ext_addr;
        logic [15:0] lp_page;
    } lpnpia_top_s;

    lpnpia_top_s st_ff;
    lpnpia_top_s nxt_st;
    logic [lpnpia_pkg::IDX_W-1:0] idx;
    logic req;
    logic win_data;
    logic dev_hit;

    lpnpia_mem_if #(.AW(EXT_AW)) mem_bus ();

    lpnpia_ext_mem #(.AW(EXT_AW)) u_mem (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .mem_if(mem_bus.mem)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Nonzero function selects the data register behind the window.
    function automatic logic is_data(input logic [1:0] fn);
        is_data = (fn != 2'(lpnpia_pkg::FN_ADDR));
    endfunction : is_data

    // Decides whether a finished window access advances the address.
    function automatic logic post_inc(input logic [1:0] fn, input logic wr);
        post_inc = (fn == 2'(lpnpia_pkg::FN_DATA_INC_RW))
            || ((fn == 2'(lpnpia_pkg::FN_DATA_INC_W)) && wr);
    endfunction : post_inc

    // Merges the low two byte lanes of a write into an old value.
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
            input logic [1:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    ////////////////////////////////////////////////////////////////////////////////
    assign idx = avs_address_in[lpnpia_pkg::BUS_AW-1:2];
    assign req = avs_read_in || avs_write_in;
    assign win_data = is_data(st_ff.func);
    assign dev_hit = (st_ff.devsel == lpnpia_pkg::EXT_DEVSEL);

    always_comb begin
        mem_bus.rd_en = 1'b0;
        mem_bus.wr_en = 1'b0;
        mem_bus.addr = st_ff.ext_addr[EXT_AW-1:0];
        mem_bus.wdata = merge16(mem_bus.rdata, avs_writedata_in[15:0], avs_byteenable_in[1:0]);
        if (st_ff.state == lpnpia_pkg::ST_IDLE && req && idx == lpnpia_pkg::IDX_IND_WIN
                && win_data && dev_hit) begin
            mem_bus.rd_en = 1'b1;
        end
        if (st_ff.state == lpnpia_pkg::ST_DONE && avs_write_in
                && idx == lpnpia_pkg::IDX_IND_WIN && win_data && dev_hit) begin
            mem_bus.wr_en = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st = st_ff;
        if (an_page_load_in) begin
            nxt_st.lp_page = an_page_in;
            nxt_st.lp_page[lpnpia_pkg::BIT_TOG] = ~an_page_in[lpnpia_pkg::BIT_TOG];
        end
        if (an_ack_update_in) begin
            nxt_st.lp_page[lpnpia_pkg::BIT_ACK] = an_ack_in;
        end
        unique case (st_ff.state)
            lpnpia_pkg::ST_IDLE: begin
                if (req) begin
                    nxt_st.state = lpnpia_pkg::ST_LOAD;
                end
            end
            lpnpia_pkg::ST_LOAD: begin
                nxt_st.state = lpnpia_pkg::ST_DONE;
                nxt_st.readdata = 16'h0000;
                unique case (idx)
                    lpnpia_pkg::IDX_LP_PAGE: nxt_st.readdata = st_ff.lp_page;
                    lpnpia_pkg::IDX_IND_CTRL: nxt_st.readdata = {st_ff.func, 9'h000, st_ff.devsel};
                    lpnpia_pkg::IDX_IND_WIN: begin
                        if (!win_data) begin
                            nxt_st.readdata = st_ff.ext_addr;
                        end else if (dev_hit) begin
                            nxt_st.readdata = mem_bus.rdata;
                        end
                    end
                    default: nxt_st.readdata = 16'h0000;
                endcase
            end
            lpnpia_pkg::ST_DONE: begin
                nxt_st.state = lpnpia_pkg::ST_IDLE;
                // partner page has no write path.
                if (avs_write_in && idx == lpnpia_pkg::IDX_IND_CTRL) begin
                    if (avs_byteenable_in[1]) begin
                        nxt_st.func = avs_writedata_in[lpnpia_pkg::FUNC_HI:lpnpia_pkg::FUNC_LO];
                    end
                    if (avs_byteenable_in[0]) begin
                        nxt_st.devsel = avs_writedata_in[lpnpia_pkg::DEV_HI:lpnpia_pkg::DEV_LO];
                    end
                end
                if (idx == lpnpia_pkg::IDX_IND_WIN) begin
                    if (!win_data && avs_write_in) begin
                        nxt_st.ext_addr = merge16(st_ff.ext_addr, avs_writedata_in[15:0],
                            avs_byteenable_in[1:0]);
                    end else if (win_data && post_inc(st_ff.func, avs_write_in)) begin
                        nxt_st.ext_addr = st_ff.ext_addr + 16'h0001;
                    end
                end
            end
            default: nxt_st.state = lpnpia_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_ff.state <= lpnpia_pkg::ST_IDLE;
            st_ff.readdata <= 16'h0000;
            st_ff.func <= lpnpia_pkg::RST_IND_CTRL[lpnpia_pkg::FUNC_HI:lpnpia_pkg::FUNC_LO];
            st_ff.devsel <= lpnpia_pkg::RST_IND_CTRL[lpnpia_pkg::DEV_HI:lpnpia_pkg::DEV_LO];
            st_ff.ext_addr <= lpnpia_pkg::RST_IND_WIN;
            st_ff.lp_page <= lpnpia_pkg::RST_LP_PAGE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_readdata_out = {16'h0000, st_ff.readdata};
    assign avs_waitrequest_out = (st_ff.state != lpnpia_pkg::ST_DONE);

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    sequence acc_start;
        st_ff.state == lpnpia_pkg::ST_IDLE && req;
    endsequence

    sequence acc_answer;
        avs_waitrequest_out ##1 avs_waitrequest_out ##1 !avs_waitrequest_out;
    endsequence

    sequence win_inc_done;
        st_ff.state == lpnpia_pkg::ST_DONE && idx == lpnpia_pkg::IDX_IND_WIN && win_data
            && post_inc(st_ff.func, avs_write_in);
    endsequence

    bus_answer_a: assert property (acc_start |-> acc_answer)
        else $error("Answer not given two cycles after request.");

    wait_low_one_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("Waitrequest low for more than one cycle.");

    more_pages_a: assert property (an_page_load_in |=>
        st_ff.lp_page[15] == $past(an_page_in[15]))
        else $error("More pages flag not captured.");

    ack_update_a: assert property (an_ack_update_in |=>
        st_ff.lp_page[14] == $past(an_ack_in))
        else $error("Acknowledge bit not updated.");

    ack_only_a: assert property (an_ack_update_in && !an_page_load_in |=>
        st_ff.lp_page[15] == $past(st_ff.lp_page[15])
        && st_ff.lp_page[13:0] == $past(st_ff.lp_page[13:0]))
        else $error("Acknowledge update disturbed other page bits.");

    page_type_a: assert property (an_page_load_in |=>
        st_ff.lp_page[13] == $past(an_page_in[13]))
        else $error("Page type not captured.");

    will_comply_a: assert property (an_page_load_in |=>
        st_ff.lp_page[12] == $past(an_page_in[12]))
        else $error("Will comply bit not captured.");

    toggle_inv_a: assert property (an_page_load_in |=>
        st_ff.lp_page[11] != $past(an_page_in[11]))
        else $error("Toggle bit not inverted.");

    payload_a: assert property (an_page_load_in |=>
        st_ff.lp_page[10:0] == $past(an_page_in[10:0]))
        else $error("Payload not captured.");

    page_ro_a: assert property (!an_page_load_in && !an_ack_update_in |=>
        $stable(st_ff.lp_page))
        else $error("Partner page changed without negotiation.");

    lp_read_a: assert property (st_ff.state == lpnpia_pkg::ST_LOAD
        && idx == lpnpia_pkg::IDX_LP_PAGE |=> st_ff.readdata == $past(st_ff.lp_page))
        else $error("Partner page not returned on read.");

    ctrl_resv_a: assert property (!avs_waitrequest_out && idx == lpnpia_pkg::IDX_IND_CTRL
        |-> avs_readdata_out[13:5] == 9'h000)
        else $error("Reserved control bits not zero.");

    ctrl_read_a: assert property (st_ff.state == lpnpia_pkg::ST_LOAD
        && idx == lpnpia_pkg::IDX_IND_CTRL
        |=> st_ff.readdata == {$past(st_ff.func), 9'h000, $past(st_ff.devsel)})
        else $error("Control register read wrong.");

    func_a: assert property (st_ff.state == lpnpia_pkg::ST_DONE && avs_write_in
        && idx == lpnpia_pkg::IDX_IND_CTRL && avs_byteenable_in[1]
        |=> st_ff.func == $past(avs_writedata_in[15:14]))
        else $error("Function field not stored.");

    func_keep_a: assert property (st_ff.state != lpnpia_pkg::ST_DONE
        |=> $stable(st_ff.func) && $stable(st_ff.devsel))
        else $error("Control fields changed outside a write.");

    devsel_store_a: assert property (st_ff.state == lpnpia_pkg::ST_DONE && avs_write_in
        && idx == lpnpia_pkg::IDX_IND_CTRL && avs_byteenable_in[0]
        |=> st_ff.devsel == $past(avs_writedata_in[4:0]))
        else $error("Device select not stored.");

    addr_read_a: assert property (st_ff.state == lpnpia_pkg::ST_LOAD
        && idx == lpnpia_pkg::IDX_IND_WIN && !win_data |=> st_ff.readdata == $past(st_ff.ext_addr))
        else $error("Window read did not return address.");

    addr_win_a: assert property (st_ff.state == lpnpia_pkg::ST_DONE && avs_write_in
        && idx == lpnpia_pkg::IDX_IND_WIN && !win_data && avs_byteenable_in[1:0] == 2'h3
        |=> st_ff.ext_addr == $past(avs_writedata_in[15:0]))
        else $error("Window write did not reach address register.");

    ctrl_no_addr_a: assert property (st_ff.state == lpnpia_pkg::ST_DONE
        && idx != lpnpia_pkg::IDX_IND_WIN |=> $stable(st_ff.ext_addr))
        else $error("Address changed by a non-window access.");

    mem_fetch_a: assert property (st_ff.state == lpnpia_pkg::ST_IDLE && req
        && idx == lpnpia_pkg::IDX_IND_WIN && win_data && dev_hit
        |=> mem_bus.rdata == $past(u_mem.st_ff.words[mem_bus.addr]))
        else $error("Window data word not fetched.");

    data_read_a: assert property (st_ff.state == lpnpia_pkg::ST_LOAD
        && idx == lpnpia_pkg::IDX_IND_WIN && win_data && dev_hit
        |=> st_ff.readdata == $past(mem_bus.rdata))
        else $error("Window read did not return data.");

    miss_read_a: assert property (st_ff.state == lpnpia_pkg::ST_LOAD
        && idx == lpnpia_pkg::IDX_IND_WIN && win_data && !dev_hit |=> st_ff.readdata == 16'h0000)
        else $error("Unselected device read not zero.");

    data_win_a: assert property (st_ff.state == lpnpia_pkg::ST_DONE && avs_write_in
        && idx == lpnpia_pkg::IDX_IND_WIN && win_data && dev_hit
        && avs_byteenable_in[1:0] == 2'h3
        |=> u_mem.st_ff.words[$past(mem_bus.addr)] == $past(avs_writedata_in[15:0]))
        else $error("Window write did not reach data register.");

    miss_drop_a: assert property (!dev_hit |-> !mem_bus.wr_en)
        else $error("Write reached memory without device select.");

    post_inc_a: assert property (win_inc_done |=>
        st_ff.ext_addr == $past(st_ff.ext_addr) + 16'h0001)
        else $error("Address not advanced after window access.");

    no_inc_a: assert property (st_ff.state == lpnpia_pkg::ST_DONE && avs_read_in
        && idx == lpnpia_pkg::IDX_IND_WIN && st_ff.func == 2'h3 |=> $stable(st_ff.ext_addr))
        else $error("Address advanced on read in write-only mode.");

    rw_inc_a: assert property (st_ff.state == lpnpia_pkg::ST_DONE && avs_read_in
        && idx == lpnpia_pkg::IDX_IND_WIN && st_ff.func == 2'h2
        |=> st_ff.ext_addr == $past(st_ff.ext_addr) + 16'h0001)
        else $error("Address not advanced on read in increment mode.");

    wr_inc_a: assert property (st_ff.state == lpnpia_pkg::ST_DONE && avs_write_in
        && idx == lpnpia_pkg::IDX_IND_WIN && st_ff.func == 2'h3
        |=> st_ff.ext_addr == $past(st_ff.ext_addr) + 16'h0001)
        else $error("Address not advanced on write in write-only mode.");

    fixed_data_a: assert property (st_ff.state == lpnpia_pkg::ST_DONE
        && idx == lpnpia_pkg::IDX_IND_WIN && st_ff.func == 2'h1 |=> $stable(st_ff.ext_addr))
        else $error("Address advanced in data mode without increment.");

    unmapped_read_a: assert property (st_ff.state == lpnpia_pkg::ST_LOAD
        && idx != lpnpia_pkg::IDX_LP_PAGE && idx != lpnpia_pkg::IDX_IND_CTRL
        && idx != lpnpia_pkg::IDX_IND_WIN |=> st_ff.readdata == 16'h0000)
        else $error("Unmapped index read not zero.");

    readdata_hold_a: assert property (st_ff.state != lpnpia_pkg::ST_LOAD |=> $stable(st_ff.readdata))
        else $error("Read data changed outside a load.");
endmodule : lpnpia_top

// ==== verification/lpnpia_an_model.sv ====
// Model of the negotiation logic that fills the partner page register.
`timescale 1ns/1ps
module lpnpia_an_model (
    input wire logic clk_in,
    output logic page_load_out,
    output logic [15:0] page_out,
    output logic ack_update_out,
    output logic ack_out
);
    initial begin
        page_load_out = 1'b0;
        page_out = 16'h5aa5;
        ack_update_out = 1'b0;
        ack_out = 1'b0;
    end
    // Outside a pulse the page lines show the inverse, so stale data is never captured.
    task send_page(input logic [15:0] page);
        @(posedge clk_in);
        page_load_out <= 1'b1;
        page_out <= page;
        @(posedge clk_in);
        page_load_out <= 1'b0;
        page_out <= ~page;
    endtask : send_page
    task send_ack(input logic ack);
        @(posedge clk_in);
        ack_update_out <= 1'b1;
        ack_out <= ack;
        @(posedge clk_in);
        ack_update_out <= 1'b0;
        ack_out <= ~ack;
    endtask : send_ack
endmodule : lpnpia_an_model

// ==== verification/tb_lp_next_page_and_indirect_access.sv ====
// Self-checking bench for the partner page and indirect access register slice.
`timescale 1ns/1ps
module tb_lp_next_page_and_indirect_access;
    logic clk_in;
    logic arst_n_in;
    logic [lpnpia_pkg::BUS_AW-1:0] avs_address_in;
    logic avs_read_in;
    logic avs_write_in;
    logic [lpnpia_pkg::BUS_DW-1:0] avs_writedata_in;
    logic [3:0] avs_byteenable_in;
    logic [lpnpia_pkg::BUS_DW-1:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic an_page_load_in;
    logic [15:0] an_page_in;
    logic an_ack_update_in;
    logic an_ack_in;
    int err_total;
    int n_checks;
    lpnpia_top #(.EXT_AW(lpnpia_pkg::EXT_AW)) u_dut (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .an_page_load_in(an_page_load_in), .an_page_in(an_page_in),
        .an_ack_update_in(an_ack_update_in), .an_ack_in(an_ack_in)
    );
    lpnpia_an_model u_an (
        .clk_in(clk_in), .page_load_out(an_page_load_in), .page_out(an_page_in),
        .ack_update_out(an_ack_update_in), .ack_out(an_ack_in)
    );
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %0t read %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Request is held until the edge that closes the cycle with waitrequest low.
    task bus(input logic wr, input logic [7:0] a, input logic [15:0] wd, output logic [31:0] rd);
        int i;
        @(posedge clk_in);
        avs_address_in <= a;
        avs_read_in <= !wr;
        avs_write_in <= wr;
        avs_writedata_in <= {16'h0000, wd};
        for (i = 0; i < 50; i++) begin
            @(posedge clk_in);
            if (avs_waitrequest_out === 1'b0) break;
        end
        if (i == 50) begin
            err_total++;
            complete_run();
        end
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask : bus
    task wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] rd;
        bus(1'b1, a, d, rd);
    endtask : wr
    task rc(input logic [7:0] a, input logic [15:0] exp);
        logic [31:0] rd;
        bus(1'b0, a, 16'h0000, rd);
        check(rd, {16'h0000, exp});
    endtask : rc
    task test_end(input string name);
        $display("test %s finished, mismatches so far %0d", name, err_total);
    endtask : test_end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n_in = 1'b0;
        avs_address_in = 8'h00;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h00000000;
        avs_byteenable_in = 4'hf;
        err_total = 0;
        n_checks = 0;
        repeat (10) @(posedge clk_in);
        arst_n_in <= 1'b1;
        rc(8'h20, 16'h2001);
        rc(8'h34, 16'h0000);
        rc(8'h38, 16'h0000);
        rc(8'h00, 16'h0000);
        test_end("reset");
        u_an.send_page(16'h9a55);
        rc(8'h20, 16'h9255);
        u_an.send_page(16'h6123);
        rc(8'h20, 16'h6923);
        u_an.send_ack(1'b0);
        rc(8'h20, 16'h2923);
        wr(8'h20, 16'hffff);
        rc(8'h20, 16'h2923);
        test_end("partner page");
        wr(8'h34, 16'hffff);
        rc(8'h34, 16'hc01f);
        wr(8'h34, 16'h001f);
        wr(8'h38, 16'h0003);
        rc(8'h38, 16'h0003);
        wr(8'h34, 16'h401f);
        wr(8'h38, 16'haaaa);
        rc(8'h38, 16'haaaa);
        rc(8'h38, 16'haaaa);
        wr(8'h34, 16'h001f);
        rc(8'h38, 16'h0003);
        wr(8'h34, 16'h801f);
        wr(8'h38, 16'h1111);
        wr(8'h38, 16'h2222);
        wr(8'h34, 16'h001f);
        rc(8'h38, 16'h0005);
        wr(8'h38, 16'h0003);
        wr(8'h34, 16'h801f);
        rc(8'h38, 16'h1111);
        rc(8'h38, 16'h2222);
        wr(8'h34, 16'h001f);
        rc(8'h38, 16'h0005);
        wr(8'h34, 16'hc01f);
        wr(8'h38, 16'h3333);
        rc(8'h38, 16'h0000);
        rc(8'h38, 16'h0000);
        wr(8'h34, 16'h001f);
        rc(8'h38, 16'h0006);
        test_end("increment");
        wr(8'h38, 16'h0003);
        wr(8'h34, 16'h4000);
        rc(8'h38, 16'h0000);
        wr(8'h38, 16'h5555);
        wr(8'h34, 16'h401f);
        rc(8'h38, 16'h1111);
        avs_byteenable_in <= 4'h1;
        wr(8'h38, 16'hbeef);
        avs_byteenable_in <= 4'hf;
        rc(8'h38, 16'h11ef);
        wr(8'h34, 16'h001f);
        wr(8'h38, 16'h0005);
        wr(8'h34, 16'h401f);
        rc(8'h38, 16'h3333);
        test_end("device select");
        @(posedge clk_in);
        arst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        rc(8'h20, 16'h2001);
        rc(8'h34, 16'h0000);
        test_end("second reset");
        complete_run();
    end
endmodule : tb_lp_next_page_and_indirect_access
